// >>> logic/ssbsem_defines.vh
// Register offsets, field positions and reset values of the buffer semaphore block
`ifndef SSBSEM_DEFINES_VH
`define SSBSEM_DEFINES_VH
`define SSBSEM_ADDR_W 12
`define SSBSEM_OFF_TASK_ACQUIRE 12'h024
`define SSBSEM_OFF_TASK_RELEASE 12'h028
`define SSBSEM_OFF_EV_END 12'h104
`define SSBSEM_OFF_EV_RXFULL 12'h110
`define SSBSEM_OFF_EV_GRANTED 12'h128
`define SSBSEM_OFF_LINKS 12'h200
`define SSBSEM_OFF_IRQ_SET 12'h304
`define SSBSEM_OFF_IRQ_CLR 12'h308
`define SSBSEM_OFF_OWNER 12'h400
`define SSBSEM_OFF_ENABLE 12'h500
`define SSBSEM_OFF_SLAVE_REQ 12'h600
`define SSBSEM_BIT_END 0
`define SSBSEM_BIT_RXFULL 1
`define SSBSEM_BIT_GRANTED 2
`define SSBSEM_BIT_LINK_END_ACQ 0
`define SSBSEM_OWN_FREE 2'h0
`define SSBSEM_OWN_CPU 2'h1
`define SSBSEM_OWN_SLAVE 2'h2
`define SSBSEM_OWN_WAIT 2'h3
`define SSBSEM_OWN_RESET 2'h1
`define SSBSEM_ENABLE_ON 4'h2
`define SSBSEM_ENABLE_RESET 4'h0
`define SSBSEM_LINKS_RESET 1'h0
`define SSBSEM_IRQEN_RESET 3'h0
`endif

// >>> logic/ssbsem_arbiter.v
// Semaphore ownership state machine between processor and serial slave engine
`timescale 1ns/10ps
`include "ssbsem_defines.vh"
module ssbsem_arbiter (
    input wire core_clk, // Clock
    input wire reset_n, // Async reset, active low
    input wire cpu_acquire, // Processor acquire request pulse
    input wire cpu_release, // Processor release pulse
    input wire slave_enabled, // Serial slave function enabled
    input wire slave_want, // Slave engine wants the buffer
    input wire slave_done, // Slave engine finished with buffer
    output reg [1:0] owner_q, // Current owner code
    output reg granted_q // One-cycle pulse when processor obtains it
);
    reg [1:0] owner_d;
    always @* begin
        owner_d = owner_q;
        case (owner_q)
            `SSBSEM_OWN_FREE: begin
                if (cpu_acquire) begin
                    owner_d = `SSBSEM_OWN_CPU;
                end else if (slave_enabled && slave_want) begin
                    owner_d = `SSBSEM_OWN_SLAVE;
                end
            end
            `SSBSEM_OWN_CPU: begin
                if (cpu_release && !cpu_acquire) begin
                    owner_d = `SSBSEM_OWN_FREE;
                end
            end
            `SSBSEM_OWN_SLAVE: begin
                if (slave_done || !slave_enabled) begin
                    owner_d = cpu_acquire ? `SSBSEM_OWN_CPU : `SSBSEM_OWN_FREE;
                end else if (cpu_acquire) begin
                    owner_d = `SSBSEM_OWN_WAIT;
                end
            end
            `SSBSEM_OWN_WAIT: begin
                if (slave_done || !slave_enabled) begin
                    owner_d = `SSBSEM_OWN_CPU;
                end
            end
            default: owner_d = `SSBSEM_OWN_FREE;
        endcase
    end
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            owner_q <= `SSBSEM_OWN_RESET;
            granted_q <= 1'b0;
        end else begin
            owner_q <= owner_d;
            granted_q <= (owner_d == `SSBSEM_OWN_CPU) && (owner_q != `SSBSEM_OWN_CPU);
        end
    end
endmodule // ssbsem_arbiter

// >>> logic/ssbsem_ctrl.v
// Buffer semaphore control with event, link and interrupt registers
// Summary of operation
// - Owner reads 0 when free, 2 when slave engine holds it.
// - Owner reads 1 while processor holds it; reset owner is processor.
// - Owner reads 3 while slave holds it and processor waits.
// - Link bit set makes each transaction-done trigger acquire; resets 0.
// - Enable-set register: write 1 enables, 0 no effect, reads state.
// - Enable-clear register: write 1 disables, 0 ignored, reads state.
// - Link register joins local events to tasks, all zero after reset.
// - Release task frees semaphore; acquire task requests it for processor.
// - Slave function active only when enable field holds 2.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`include "ssbsem_defines.vh"
module ssbsem_ctrl (
    input wire core_clk, // 250 MHz clock
    input wire reset_n, // Async reset, active low
    input wire [11:0] reg_addr, // Register byte address
    input wire [31:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    output reg [31:0] reg_rdata_q, // Read data, cycle after strobe
    input wire slave_done, // Transaction-done pulse from slave engine
    input wire slave_rxfull, // Receive-buffer-full pulse from slave engine
    output wire slave_active, // Slave function enabled
    output wire slave_owns, // Slave engine may use buffer
    output wire irq // Level interrupt
);
    // ********************
    // Register writes
    // ********************
    wire wr_acq = reg_wr && (reg_addr == `SSBSEM_OFF_TASK_ACQUIRE) && reg_wdata[0];
    wire wr_rel = reg_wr && (reg_addr == `SSBSEM_OFF_TASK_RELEASE) && reg_wdata[0];
    reg [2:0] flags_q;
    reg [2:0] irqen_q;
    reg link_q;
    reg [3:0] enable_q;
    reg slave_req_q;
    wire [1:0] owner;
    wire granted;
    wire slave_ok;
    assign slave_ok = (enable_q == `SSBSEM_ENABLE_ON);
    assign slave_active = slave_ok;
    wire cpu_acq = wr_acq || (link_q && slave_done);
    ssbsem_arbiter u_arb (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .cpu_acquire(cpu_acq),
        .cpu_release(wr_rel),
        .slave_enabled(slave_ok),
        .slave_want(slave_req_q),
        .slave_done(slave_done),
        .owner_q(owner),
        .granted_q(granted)
    );
    // Slave owns in states 2 and 3
    assign slave_owns = owner[1];
    wire [2:0] ev;
    assign ev = {granted, slave_rxfull, slave_done};
    // ********************
    // Flags, links, enables
    // ********************
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_flag
            localparam [11:0] OFF = (i == 0) ? `SSBSEM_OFF_EV_END :
                (i == 1) ? `SSBSEM_OFF_EV_RXFULL : `SSBSEM_OFF_EV_GRANTED;
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    flags_q[i] <= 1'b0;
                end else if (ev[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (reg_wr && reg_addr == OFF) begin
                    flags_q[i] <= reg_wdata[0];
                end
            end
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    irqen_q[i] <= 1'b0;
                end else if (reg_wr && reg_addr == `SSBSEM_OFF_IRQ_SET && reg_wdata[i]) begin
                    irqen_q[i] <= 1'b1;
                end else if (reg_wr && reg_addr == `SSBSEM_OFF_IRQ_CLR && reg_wdata[i]) begin
                    irqen_q[i] <= 1'b0;
                end
            end
        end
    endgenerate
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_q <= `SSBSEM_LINKS_RESET;
            enable_q <= `SSBSEM_ENABLE_RESET;
            slave_req_q <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `SSBSEM_OFF_LINKS) begin
                link_q <= reg_wdata[`SSBSEM_BIT_LINK_END_ACQ];
            end
            if (reg_addr == `SSBSEM_OFF_ENABLE) begin
                enable_q <= reg_wdata[3:0];
            end
            if (reg_addr == `SSBSEM_OFF_SLAVE_REQ) begin
                slave_req_q <= reg_wdata[0];
            end
        end
    end
    // Level interrupt from unmasked sticky flags
    assign irq = |(flags_q & irqen_q);
    // ********************
    // Read path
    // ********************
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h00000000;
        case (reg_addr)
            `SSBSEM_OFF_EV_END: rd_d[0] = flags_q[`SSBSEM_BIT_END];
            `SSBSEM_OFF_EV_RXFULL: rd_d[0] = flags_q[`SSBSEM_BIT_RXFULL];
            `SSBSEM_OFF_EV_GRANTED: rd_d[0] = flags_q[`SSBSEM_BIT_GRANTED];
            `SSBSEM_OFF_LINKS: rd_d[0] = link_q;
            `SSBSEM_OFF_IRQ_SET: rd_d[2:0] = irqen_q;
            `SSBSEM_OFF_IRQ_CLR: rd_d[2:0] = irqen_q;
            `SSBSEM_OFF_OWNER: rd_d[1:0] = owner;
            `SSBSEM_OFF_ENABLE: rd_d[3:0] = enable_q;
            `SSBSEM_OFF_SLAVE_REQ: rd_d[0] = slave_req_q;
            default: rd_d = 32'h00000000;
        endcase
    end
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_d;
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end
endmodule // ssbsem_ctrl

// >>> dv/ssbsem_ctrl_assertions.sv
// Port checks of the buffer semaphore control
`timescale 1ns/10ps
module ssbsem_ctrl_checker (
    input wire core_clk, // Clock
    input wire reset_n, // Reset, active low
    input wire [11:0] reg_addr, // Address
    input wire [31:0] reg_wdata, // Write data
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire [31:0] reg_rdata_q, // Read data
    input wire slave_done, // Done pulse
    input wire slave_rxfull, // Rx full pulse
    input wire slave_active, // Slave enabled
    input wire slave_owns, // Slave holds buffer
    input wire irq // Interrupt
);
// ****
// Checks
// ****
default clocking @(posedge core_clk); endclocking
default disable iff (!reset_n);
wire en_wr = reg_wr && reg_addr == 12'h500;
reset_vals_a: assert property ($rose(reset_n) |-> !slave_owns && !irq && !slave_active)
    else $error("outputs wrong after reset");
rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data not zero when idle");
owner_read_a: assert property (reg_rd && reg_addr == 12'h400 |=> reg_rdata_q[1] == $past(slave_owns))
    else $error("owner read disagrees with slave ownership");
active_set_a: assert property (en_wr |=> slave_active == ($past(reg_wdata[3:0]) == 4'h2))
    else $error("slave active does not follow enable");
active_hold_a: assert property (!en_wr |=> $stable(slave_active))
    else $error("slave active changed without write");
irq_off_a: assert property (reg_wr && reg_addr == 12'h308 && reg_wdata[2:0] == 3'h7 |=> !irq)
    else $error("interrupt stays after all disabled");
acq_first_a: assert property (reg_wr && reg_addr == 12'h024 && reg_wdata[0] && !slave_owns
    |=> !slave_owns [*2])
    else $error("slave took buffer over acquire");
// A disabling write reaches the owner one edge later than a done pulse does
owner_leave_a: assert property ($fell(slave_owns) |-> $past(slave_done) || $past(en_wr, 2))
    else $error("slave lost buffer without cause");
cover property (slave_owns && reg_wr && reg_addr == 12'h024);
cover property ($rose(irq));
cover property ($fell(slave_owns));
endmodule // ssbsem_ctrl_checker
bind ssbsem_ctrl ssbsem_ctrl_checker chk_i (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .slave_done(slave_done), .slave_rxfull(slave_rxfull),
    .slave_active(slave_active), .slave_owns(slave_owns), .irq(irq));

// >>> dv/ssbsem_ctrl_tb_top.sv
// Register-level testbench of the buffer semaphore control
`timescale 1ns/10ps
module ssbsem_ctrl_tb_top;
reg core_clk = 1'b0;
reg reset_n = 1'b0;
reg [11:0] reg_addr = 12'h000;
reg [31:0] reg_wdata = 32'h0;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg slave_done = 1'b0;
reg slave_rxfull = 1'b0;
wire [31:0] reg_rdata_q;
wire slave_active, slave_owns, irq;
integer mismatches = 0;
integer num_checks = 0;
ssbsem_ctrl uut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .slave_done(slave_done), .slave_rxfull(slave_rxfull), .slave_active(slave_active),
    .slave_owns(slave_owns), .irq(irq));
initial forever #2 core_clk = ~core_clk;
// ****
// Bus tasks
// ****
task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
// Idle cycles after each step let the two-cycle grant land
task wr(input [11:0] a, input [31:0] d);
    begin
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    end
endtask
task rd(input [11:0] a, input [31:0] exp);
    begin
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_q, exp);
    end
endtask
task pulse(input rx);
    begin
        @(posedge core_clk);
        slave_done <= !rx;
        slave_rxfull <= rx;
        @(posedge core_clk);
        slave_done <= 1'b0;
        slave_rxfull <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    end
endtask
task give_verdict;
    begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
endtask
initial begin
    #20000;
    mismatches = mismatches + 1;
    give_verdict;
end
initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(12'h400, 32'h1);
    rd(12'h200, 32'h0);
    rd(12'h304, 32'h0);
    rd(12'h128, 32'h0);
    rd(12'h7FC, 32'h0);
    chk(slave_active, 1'b0);
    $display("reset test done");
    wr(12'h028, 32'h1);
    rd(12'h400, 32'h0);
    wr(12'h500, 32'h2);
    chk(slave_active, 1'b1);
    wr(12'h600, 32'h1);
    rd(12'h400, 32'h2);
    wr(12'h304, 32'h6);
    wr(12'h304, 32'h0);
    rd(12'h308, 32'h6);
    wr(12'h024, 32'h1);
    rd(12'h400, 32'h3);
    pulse(1'b0);
    rd(12'h400, 32'h1);
    rd(12'h128, 32'h1);
    chk(irq, 1'b1);
    wr(12'h128, 32'h0);
    chk(irq, 1'b0);
    pulse(1'b1);
    chk(irq, 1'b1);
    wr(12'h308, 32'h0);
    chk(irq, 1'b1);
    wr(12'h308, 32'h7);
    chk(irq, 1'b0);
    rd(12'h304, 32'h0);
    $display("owner and irq test done");
    wr(12'h028, 32'h1);
    wr(12'h600, 32'h0);
    wr(12'h200, 32'h1);
    pulse(1'b0);
    rd(12'h400, 32'h1);
    wr(12'h028, 32'h1);
    wr(12'h600, 32'h1);
    wr(12'h600, 32'h0);
    wr(12'h200, 32'h0);
    pulse(1'b0);
    rd(12'h400, 32'h0);
    wr(12'h024, 32'h1);
    rd(12'h400, 32'h1);
    wr(12'h500, 32'h0);
    chk(slave_active, 1'b0);
    $display("link test done");
    rd(12'h104, 32'h1);
    rd(12'h110, 32'h1);
    wr(12'h110, 32'h0);
    rd(12'h110, 32'h0);
    wr(12'h104, 32'h0);
    rd(12'h104, 32'h0);
    // Clear and event in the same cycle: the event must win
    @(posedge core_clk);
    reg_addr <= 12'h104;
    reg_wdata <= 32'h0;
    reg_wr <= 1'b1;
    slave_done <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    slave_done <= 1'b0;
    rd(12'h104, 32'h1);
    wr(12'h500, 32'h3);
    chk(slave_active, 1'b0);
    wr(12'h500, 32'h2);
    wr(12'h600, 32'h1);
    wr(12'h028, 32'h1);
    chk(slave_owns, 1'b1);
    wr(12'h500, 32'h0);
    chk(slave_owns, 1'b0);
    rd(12'h400, 32'h0);
    $display("flag and disable test done");
    give_verdict;
end
endmodule // ssbsem_ctrl_tb_top
